/* hdl/tseq_top.sv */
// Trace sequencer with arm logic, trigger lines and Wishbone registers.
// Assumes bus state inputs synchronous to i_mclk; i_bus_valid marks a
// qualified analyzer clock.
`include "tseq_defines.svh"
`default_nettype none
module tseq_top #(
  parameter int SIMPLE_MAX = 5,  // Most terms in simple mode
  parameter int NTERM      = 8   // Terms in complex mode
) (
  input  wire logic        i_mclk,       // Clock, 10 MHz
  input  wire logic        i_rst,        // Async reset, high
  input  wire logic        i_wb_cyc,     // Wishbone cycle
  input  wire logic        i_wb_stb,     // Wishbone strobe
  input  wire logic        i_wb_we,      // Wishbone write
  input  wire logic [7:0]  i_wb_adr,     // Byte address
  input  wire logic [3:0]  i_wb_sel,     // Byte enables
  input  wire logic [31:0] i_wb_dat,     // Write data
  output logic      [31:0] o_wb_dat,     // Read data
  output logic             o_wb_ack,     // Acknowledge
  input  wire logic [15:0] i_bus_state,  // Processor bus state
  input  wire logic        i_bus_valid,  // Qualified analyzer clock
  input  wire logic        i_bnc_trig,   // Coaxial trigger in
  input  wire logic        i_cmb_trig,   // Measurement bus trigger in
  output logic             o_bnc_trig,   // Coaxial trigger out
  output logic             o_cmb_trig,   // Measurement bus trigger out
  output logic             o_cross_trigger_a, // Line A level
  output logic             o_cross_trigger_b, // Line B level
  output logic             o_break,      // Break to monitor
  output logic             o_store,      // Store this state
  output logic             o_prestore,   // Prestore this state
  output logic             o_trigger     // Trigger found
);
  tseq_pkg::tseq_word_t pat_q [`TSEQ_NPAT];
  tseq_pkg::tseq_word_t pri_q [NTERM];
  tseq_pkg::tseq_word_t sec_q [NTERM];
  tseq_pkg::tseq_word_t ctrl_q;
  tseq_pkg::tseq_word_t rng_q;
  tseq_pkg::tseq_word_t sto_q;
  tseq_pkg::tseq_word_t pre_q;
  tseq_pkg::tseq_word_t rd_d;
  tseq_pkg::tseq_word_t bm;
  tseq_pkg::tseq_word_t wv;
  tseq_pkg::tseq_arm_e  arm_q;
  tseq_pkg::tseq_arm_e  arm_w;
  tseq_pkg::tseq_run_e  run_q;
  tseq_pkg::tseq_term_t term_q;
  tseq_pkg::tseq_term_t nxt;
  tseq_pkg::tseq_term_t last;
  tseq_pkg::tseq_term_t trg_term;
  logic [7:0]       xt_q;
  logic [NTERM-1:0] pri_hit;
  logic [NTERM-1:0] sec_hit;
  logic sto_hit;
  logic pre_hit;
  logic cfg_cx;
  logic ack_q;
  logic arm_err_q;
  logic armed_q;
  logic trig_q;
  logic start_q;
  logic stop_q;
  logic step;
  logic take;
  logic fire;
  logic wr;
  logic line_a;
  logic line_b;
  logic drv_a;
  logic drv_b;

  tseq_res_if u_res ();

  //////////////////////////////////////////////////////////////////////
  // Bus slave

  // Write lands on the edge where the master sees ack
  assign wr  = i_wb_cyc & i_wb_stb & i_wb_we & ack_q;
  assign bm  = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign wv  = i_wb_dat & bm;
  assign cfg_cx   = ctrl_q[`TSEQ_C_CX];
  assign trg_term = ctrl_q[`TSEQ_C_TRG];
  assign last     = ctrl_q[`TSEQ_C_CNT] - 3'h1;

  // Ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ack_q    <= 1'b0;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      ack_q    <= i_wb_cyc & i_wb_stb & ~ack_q;
      o_wb_ack <= i_wb_cyc & i_wb_stb & ~ack_q;
      if (i_wb_cyc & i_wb_stb & ~ack_q) begin
        o_wb_dat <= rd_d;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (i_wb_adr[7:5])
      `TSEQ_A_PAT: rd_d = pat_q[i_wb_adr[4:2]];
      `TSEQ_A_PRI: rd_d = pri_q[i_wb_adr[4:2]];
      `TSEQ_A_SEC: rd_d = sec_q[i_wb_adr[4:2]];
      3'h0: begin
        unique case (i_wb_adr)
          `TSEQ_A_CTRL:  rd_d = ctrl_q;
          `TSEQ_A_ARM:   rd_d = {29'h0, arm_q};
          `TSEQ_A_XTRIG: rd_d = {24'h0, xt_q};
          `TSEQ_A_STAT:  rd_d = {24'h0, cfg_cx, arm_err_q, run_q == tseq_pkg::TSEQ_RUN,
                                 trig_q, armed_q, term_q};
          `TSEQ_A_RANGE: rd_d = rng_q;
          `TSEQ_A_STO:   rd_d = sto_q;
          `TSEQ_A_PRE:   rd_d = pre_q;
          default:       rd_d = 32'h0000_0000;
        endcase
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Control; init restores simple mode, start and stop are pulses
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q  <= `TSEQ_CTRL_RST;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end else begin
      start_q <= 1'b0;
      stop_q  <= 1'b0;
      if (wr && i_wb_adr == `TSEQ_A_CTRL) begin
        if (wv[`TSEQ_C_INIT]) begin
          ctrl_q <= `TSEQ_CTRL_RST;
        end else begin
          ctrl_q <= (ctrl_q & ~bm) | wv;
          // Term 0 may never be the trigger term
          if ((ctrl_q[`TSEQ_C_TRG] & ~bm[`TSEQ_C_TRG] | wv[`TSEQ_C_TRG]) == 3'h0) begin
            ctrl_q[`TSEQ_C_TRG] <= 3'h1;
          end
          // Simple chain clamped to one..five terms
          if ((wv[`TSEQ_C_CNT] == 3'h0) && bm[8]) begin
            ctrl_q[`TSEQ_C_CNT] <= 3'h1;
          end else if ((wv[`TSEQ_C_CNT] > 3'(SIMPLE_MAX)) && bm[8]) begin
            ctrl_q[`TSEQ_C_CNT] <= 3'(SIMPLE_MAX);
          end
          start_q <= wv[`TSEQ_C_START];
          stop_q  <= wv[`TSEQ_C_STOP];
        end
      end
    end
  end

  // Arm condition; negated forms refused in timing mode
  assign arm_w = tseq_pkg::tseq_arm_e'(wv[2:0]);
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      arm_q     <= tseq_pkg::TSEQ_ARM_ALWAYS;
      arm_err_q <= 1'b0;
    end else if (wr && i_wb_adr == `TSEQ_A_CTRL && wv[`TSEQ_C_INIT]) begin
      arm_q     <= tseq_pkg::TSEQ_ARM_ALWAYS;
      arm_err_q <= 1'b0;
    end else if (wr && i_wb_adr == `TSEQ_A_ARM && i_wb_sel[0]) begin
      if (wv[2:0] > 3'h4 || (ctrl_q[`TSEQ_C_TIME] &&
          (arm_w == tseq_pkg::TSEQ_ARM_NE_A || arm_w == tseq_pkg::TSEQ_ARM_NE_B))) begin
        arm_err_q <= 1'b1;
      end else begin
        arm_q     <= arm_w;
        arm_err_q <= 1'b0;
      end
    end
  end

  // Trigger line routing options
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      xt_q <= 8'h00;
    end else if (wr && i_wb_adr == `TSEQ_A_XTRIG && i_wb_sel[0]) begin
      xt_q <= wv[7:0];
    end
  end

  // Range, storage and prestore qualifiers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rng_q <= 32'h0000_0000;
      sto_q <= `TSEQ_STO_RST; // Store every state until told otherwise
      pre_q <= 32'h0000_0000;
    end else if (wr) begin
      if (i_wb_adr == `TSEQ_A_RANGE) rng_q <= (rng_q & ~bm) | wv;
      if (i_wb_adr == `TSEQ_A_STO)   sto_q <= (sto_q & ~bm) | wv;
      if (i_wb_adr == `TSEQ_A_PRE)   pre_q <= (pre_q & ~bm) | wv;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Comparators and per-term qualifiers

  // Range compare, inclusive bounds
  assign u_res.rng_hit = i_bus_state >= rng_q[`TSEQ_R_LO]
                       && i_bus_state <= rng_q[`TSEQ_R_HI];
  // Arm is an operand only in complex mode
  assign u_res.arm_ok  = armed_q & cfg_cx;

  genvar gi;
  generate
    for (gi = 0; gi < `TSEQ_NPAT; gi++) begin : g_pat
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          pat_q[gi] <= 32'h0000_0000;
        end else if (wr && i_wb_adr[7:5] == `TSEQ_A_PAT && i_wb_adr[4:2] == 3'(gi)) begin
          pat_q[gi] <= (pat_q[gi] & ~bm) | wv;
        end
      end
      // Masked equality; clear care bits match anything
      assign u_res.pat_hit[gi] = ((i_bus_state ^ pat_q[gi][`TSEQ_P_VAL])
                                 & pat_q[gi][`TSEQ_P_CARE]) == 16'h0000;
    end
    for (gi = 0; gi < NTERM; gi++) begin : g_term
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          pri_q[gi] <= 32'h0000_0000;
          sec_q[gi] <= 32'h0000_0000;
        end else if (wr && i_wb_adr[4:2] == 3'(gi)) begin
          if (i_wb_adr[7:5] == `TSEQ_A_PRI) pri_q[gi] <= (pri_q[gi] & ~bm) | wv;
          if (i_wb_adr[7:5] == `TSEQ_A_SEC) sec_q[gi] <= (sec_q[gi] & ~bm) | wv;
        end
      end
      tseq_qual u_pri (.i_cx(cfg_cx), .i_q(pri_q[gi]), .res(u_res.qual), .o_hit(pri_hit[gi]));
      tseq_qual u_sec (.i_cx(cfg_cx), .i_q(sec_q[gi]), .res(u_res.qual), .o_hit(sec_hit[gi]));
    end
  endgenerate

  tseq_qual u_sto (.i_cx(cfg_cx), .i_q(sto_q), .res(u_res.qual), .o_hit(sto_hit));
  tseq_qual u_pre (.i_cx(cfg_cx), .i_q(pre_q), .res(u_res.qual), .o_hit(pre_hit));

  //////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next term; primary branch checked first
  always_comb begin
    step = (run_q == tseq_pkg::TSEQ_RUN) && i_bus_valid && armed_q;
    take = 1'b0;
    fire = 1'b0;
    nxt  = term_q;
    if (step && pri_hit[term_q]) begin
      take = 1'b1;
      if (cfg_cx) begin
        nxt = pri_q[term_q][`TSEQ_Q_TGT];
      end else if (term_q == last) begin
        fire = 1'b1;
      end else begin
        nxt = term_q + 3'h1;
      end
    end else if (step && sec_hit[term_q]) begin
      take = 1'b1;
      // Restart in simple mode, free target in complex
      nxt = cfg_cx ? sec_q[term_q][`TSEQ_Q_TGT] : 3'h0;
    end
    if (take && cfg_cx && nxt == trg_term) begin
      fire = 1'b1;
    end
  end

  // Term and run state; frozen after trigger
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      run_q  <= tseq_pkg::TSEQ_IDLE;
      term_q <= 3'h0;
      trig_q <= 1'b0;
    end else if (start_q) begin
      run_q  <= tseq_pkg::TSEQ_RUN;
      term_q <= 3'h0;
      trig_q <= 1'b0;
    end else begin
      unique case (run_q)
        tseq_pkg::TSEQ_IDLE: ;
        tseq_pkg::TSEQ_RUN: begin
          if (stop_q) begin
            run_q <= tseq_pkg::TSEQ_IDLE;
          end else if (take) begin
            term_q <= nxt;
            if (fire) begin
              trig_q <= 1'b1;
              run_q  <= tseq_pkg::TSEQ_DONE;
            end
          end
        end
        tseq_pkg::TSEQ_DONE: if (stop_q) run_q <= tseq_pkg::TSEQ_IDLE;
        default: run_q <= tseq_pkg::TSEQ_IDLE;
      endcase
    end
  end

  // Arming; negated forms decided once, at start
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      armed_q <= 1'b0;
    end else if (start_q) begin
      unique case (arm_q)
        tseq_pkg::TSEQ_ARM_ALWAYS: armed_q <= 1'b1;
        tseq_pkg::TSEQ_ARM_EQ_A:   armed_q <= line_a;
        tseq_pkg::TSEQ_ARM_EQ_B:   armed_q <= line_b;
        tseq_pkg::TSEQ_ARM_NE_A:   armed_q <= ~line_a;
        tseq_pkg::TSEQ_ARM_NE_B:   armed_q <= ~line_b;
        default:                   armed_q <= 1'b1;
      endcase
    end else if (run_q == tseq_pkg::TSEQ_RUN) begin
      if ((arm_q == tseq_pkg::TSEQ_ARM_EQ_A && line_a)
          || (arm_q == tseq_pkg::TSEQ_ARM_EQ_B && line_b)) begin
        armed_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Trigger lines and outputs

  // Our own drive kept apart so the coax echo cannot latch
  assign drv_a  = trig_q & xt_q[`TSEQ_X_TG_A];
  assign drv_b  = trig_q & xt_q[`TSEQ_X_TG_B];
  assign line_a = drv_a | (i_bnc_trig & xt_q[`TSEQ_X_BNC_A])
                | (i_cmb_trig & xt_q[`TSEQ_X_CMB_A]);
  assign line_b = drv_b | (i_bnc_trig & xt_q[`TSEQ_X_BNC_B])
                | (i_cmb_trig & xt_q[`TSEQ_X_CMB_B]);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_cross_trigger_a <= 1'b0;
      o_cross_trigger_b <= 1'b0;
      o_bnc_trig        <= 1'b0;
      o_cmb_trig        <= 1'b0;
      o_break           <= 1'b0;
      o_store           <= 1'b0;
      o_prestore        <= 1'b0;
      o_trigger         <= 1'b0;
    end else begin
      o_cross_trigger_a <= line_a;
      o_cross_trigger_b <= line_b;
      o_bnc_trig <= (drv_a & xt_q[`TSEQ_X_BNC_A]) | (drv_b & xt_q[`TSEQ_X_BNC_B]);
      o_cmb_trig <= (drv_a & xt_q[`TSEQ_X_CMB_A]) | (drv_b & xt_q[`TSEQ_X_CMB_B]);
      o_break    <= (line_a & xt_q[`TSEQ_X_BRK_A]) | (line_b & xt_q[`TSEQ_X_BRK_B]);
      o_store    <= (run_q != tseq_pkg::TSEQ_IDLE) && i_bus_valid && sto_hit;
      o_prestore <= (run_q != tseq_pkg::TSEQ_IDLE) && i_bus_valid && pre_hit
                    && !sto_hit;
      o_trigger  <= trig_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_init;
    wr && i_wb_adr == `TSEQ_A_CTRL && wv[`TSEQ_C_INIT];
  endsequence
  sequence s_ne_start;
    start_q && arm_q == tseq_pkg::TSEQ_ARM_NE_A && line_a;
  endsequence

  property p_simple_last;
    $rose(trig_q) && !cfg_cx |-> $past(term_q) == $past(last);
  endproperty
  a_simple_last: assert property (p_simple_last) else $error("simple trigger off last");

  property p_cx_entry;
    $rose(trig_q) && cfg_cx |-> term_q == trg_term && term_q != 3'h0;
  endproperty
  a_cx_entry: assert property (p_cx_entry) else $error("complex trigger term wrong");

  property p_simple_bound;
    // A restart may follow a complex run whose term was high; start_q clears it
    !cfg_cx && run_q == tseq_pkg::TSEQ_RUN && !start_q |-> term_q < 3'(SIMPLE_MAX);
  endproperty
  a_simple_bound: assert property (p_simple_bound) else $error("simple term too high");

  property p_init;
    s_init |=> !cfg_cx && arm_q == tseq_pkg::TSEQ_ARM_ALWAYS;
  endproperty
  a_init: assert property (p_init) else $error("init left old setup");

  property p_timing_refuse;
    wr && i_wb_adr == `TSEQ_A_ARM && i_wb_sel[0] && ctrl_q[`TSEQ_C_TIME]
      && wv[2:0] == 3'h3 |=> $stable(arm_q) && arm_err_q;
  endproperty
  a_timing_refuse: assert property (p_timing_refuse) else $error("negated arm taken");

  property p_ne_never;
    s_ne_start |=> !armed_q [*2];
  endproperty
  a_ne_never: assert property (p_ne_never) else $error("negated arm armed");

  property p_priority;
    step && pri_hit[term_q] && sec_hit[term_q] && !cfg_cx && term_q != last
      |=> term_q == $past(term_q) + 3'h1;
  endproperty
  a_priority: assert property (p_priority) else $error("secondary beat primary");

  property p_break;
    line_a && xt_q[`TSEQ_X_BRK_A] |=> o_break;
  endproperty
  a_break: assert property (p_break) else $error("no break on line");

  property p_store;
    o_store |-> $past(sto_hit) && $past(i_bus_valid);
  endproperty
  a_store: assert property (p_store) else $error("unqualified store");

  property p_tgout;
    $rose(trig_q) && xt_q[`TSEQ_X_TG_A] |=> o_cross_trigger_a;
  endproperty
  a_tgout: assert property (p_tgout) else $error("line A not driven");
endmodule : tseq_top
`default_nettype wire

/* shared/tseq_defines.svh */
// Constants of the trace sequencer: register offsets and bit fields.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
// Operation
// - Simple mode chains one to five terms; leaving the last by primary branch triggers.
// - Complex mode always holds exactly eight terms.
// - Complex trigger term is any but the first; entering it triggers.
// - Complex qualifiers use eight pattern comparators and one range comparator.
// - Patterns form two sets combined by a set operator.
// - Reset or initialisation selects the simple configuration.
// - In timing mode the negated arm form is refused.
// - Arm condition feeds qualifiers only in complex mode.
// - Option bits choose which trigger line the analyzer drives on trigger.
// - Each trigger line can connect to the rear coaxial connector.
// - Each trigger line can connect to the measurement bus trigger.
// - Either trigger line can optionally break execution into the monitor.
// - Secondary branch restarts in simple mode, branches per term in complex.
// - Every term has a programmable primary branch condition.
// - A prestore qualifier marks states captured ahead of stored ones.
// - Only states meeting the storage qualifier are written to trace memory.
// - Negated arm: line high at start never arms, else arms at once.
// - Reset or initialisation sets the arm condition to always armed.
`ifndef TSEQ_DEFINES_SVH
`define TSEQ_DEFINES_SVH
`define TSEQ_A_CTRL  8'h00
`define TSEQ_A_ARM   8'h04
`define TSEQ_A_XTRIG 8'h08
`define TSEQ_A_STAT  8'h0C
`define TSEQ_A_RANGE 8'h10
`define TSEQ_A_STO   8'h14
`define TSEQ_A_PRE   8'h18
`define TSEQ_A_PAT   3'h1
`define TSEQ_A_PRI   3'h2
`define TSEQ_A_SEC   3'h3
`define TSEQ_NPAT    8
`define TSEQ_C_CX    0
`define TSEQ_C_START 1
`define TSEQ_C_STOP  2
`define TSEQ_C_INIT  3
`define TSEQ_C_TIME  4
`define TSEQ_C_TRG   7:5
`define TSEQ_C_CNT   10:8
`define TSEQ_CTRL_RST 32'h0000_0120
`define TSEQ_STO_RST  32'h0010_0000
`define TSEQ_X_TG_A  0
`define TSEQ_X_TG_B  1
`define TSEQ_X_BNC_A 2
`define TSEQ_X_BNC_B 3
`define TSEQ_X_CMB_A 4
`define TSEQ_X_CMB_B 5
`define TSEQ_X_BRK_A 6
`define TSEQ_X_BRK_B 7
`define TSEQ_Q_SETA  7:0
`define TSEQ_Q_SETB  15:8
`define TSEQ_Q_OP    17:16
`define TSEQ_Q_RNG   18
`define TSEQ_Q_ARM   19
`define TSEQ_Q_ANY   20
`define TSEQ_Q_TGT   26:24
`define TSEQ_P_VAL   15:0
`define TSEQ_P_CARE  31:16
`define TSEQ_R_LO    15:0
`define TSEQ_R_HI    31:16
`endif

/* shared/tseq_pkg.sv */
// Types of the trace sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package tseq_pkg;
  typedef logic [31:0] tseq_word_t;
  typedef logic [2:0]  tseq_term_t;
  typedef enum logic [2:0] {
    TSEQ_ARM_ALWAYS = 3'b000,
    TSEQ_ARM_EQ_A   = 3'b001,
    TSEQ_ARM_EQ_B   = 3'b010,
    TSEQ_ARM_NE_A   = 3'b011,
    TSEQ_ARM_NE_B   = 3'b100
  } tseq_arm_e;
  typedef enum logic [1:0] {
    TSEQ_IDLE = 2'b00,
    TSEQ_RUN  = 2'b01,
    TSEQ_DONE = 2'b10
  } tseq_run_e;
  typedef enum logic [1:0] {
    TSEQ_OP_A     = 2'b00,
    TSEQ_OP_OR    = 2'b01,
    TSEQ_OP_AND   = 2'b10,
    TSEQ_OP_ANDN  = 2'b11
  } tseq_op_e;
endpackage : tseq_pkg
`default_nettype wire

/* shared/tseq_res_if.sv */
// Comparator results shared by all qualifier evaluators.
// Assumes the defines header is on the include path.
`include "tseq_defines.svh"
`default_nettype none
interface tseq_res_if;
  logic [`TSEQ_NPAT-1:0] pat_hit;
  logic                  rng_hit;
  logic                  arm_ok;
  modport src  (output pat_hit, output rng_hit, output arm_ok);
  modport qual (input pat_hit, input rng_hit, input arm_ok);
endinterface : tseq_res_if
`default_nettype wire

/* hdl/tseq_qual.sv */
// One qualifier evaluator: pattern sets, range and arm into one hit.
// Assumes comparator results are already valid for the current state.
`include "tseq_defines.svh"
`default_nettype none
module tseq_qual (
  input  wire logic               i_cx,   // Complex configuration
  input  wire tseq_pkg::tseq_word_t i_q,  // Qualifier word
  tseq_res_if.qual                res,    // Comparator results
  output logic                    o_hit   // Qualifier true
);
  logic a;
  logic b;
  logic s;

  // Set results and set operator
  always_comb begin
    a = |(i_q[`TSEQ_Q_SETA] & res.pat_hit);
    b = |(i_q[`TSEQ_Q_SETB] & res.pat_hit);
    unique case (tseq_pkg::tseq_op_e'(i_q[`TSEQ_Q_OP]))
      tseq_pkg::TSEQ_OP_A:    s = a;
      tseq_pkg::TSEQ_OP_OR:   s = a | b;
      tseq_pkg::TSEQ_OP_AND:  s = a & b;
      tseq_pkg::TSEQ_OP_ANDN: s = a & ~b;
    endcase
    // Simple mode sees only set A, no range and no arm
    if (i_cx) begin
      o_hit = s | (i_q[`TSEQ_Q_RNG] & res.rng_hit)
            | (i_q[`TSEQ_Q_ARM] & res.arm_ok) | i_q[`TSEQ_Q_ANY];
    end else begin
      o_hit = a | i_q[`TSEQ_Q_ANY];
    end
  end
endmodule : tseq_qual
`default_nettype wire

/* test/tseq_bus_model.sv */
// Far-side model: processor bus presenting qualified states.
// Assumes the bench commands one state per qualified clock.
`default_nettype none
module tseq_bus_model (
  input  wire logic        i_mclk,  // Analyzer clock
  input  wire logic [15:0] i_state, // Commanded state
  input  wire logic        i_valid, // Commanded qualify
  output logic      [15:0] o_state, // Bus state lines
  output logic             o_valid  // Qualified clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last_q = 16'h0000;
  // Idle bus shows the inverse of the last state, never a stale copy
  always @(posedge i_mclk) begin
    if (i_valid) last_q <= i_state;
  end
  assign o_state = i_valid ? i_state : ~last_q;
  assign o_valid = i_valid;
endmodule : tseq_bus_model
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench: sequencer runs compared with a term-count model.
// Assumes tseq_top, the bus model and the defines header are available.
`include "tseq_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] P = 16'hA5C3;
  localparam logic [15:0] Q = 16'h3C5A;
  localparam logic [15:0] M = 16'h6666; // Care bits where P and Q agree
  logic        i_mclk = 0, i_rst = 1, cyc = 0, stb = 0, we = 0, valid = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, rnd = 32'h93D7, o_wb_dat;
  logic [15:0] st = 16'h0, bus_state;
  logic        o_wb_ack, bus_valid, bnc, coordinated_measurement_bus, xa, xb, brk, sto, pre, trg;
  int          bad_count = 0, samples_checked = 0, cycles = 0, term;
  logic        fired, bnc_in = 1'b0, armed = 1'b1, orq = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  tseq_top i_tseq_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_bus_state(bus_state), .i_bus_valid(bus_valid),
    .i_bnc_trig(bnc_in), .i_cmb_trig(1'b0), .o_bnc_trig(bnc), .o_cmb_trig(coordinated_measurement_bus),
    .o_cross_trigger_a(xa), .o_cross_trigger_b(xb), .o_break(brk), .o_store(sto),
    .o_prestore(pre), .o_trigger(trg));
  tseq_bus_model i_tseq_bus_model (.i_mclk(i_mclk), .i_state(st), .i_valid(valid),
    .o_state(bus_state), .o_valid(bus_valid));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // Classic cycle: ack seen before the edge's own updates land
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge i_mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge i_mclk); while (o_wb_ack !== 1'b1);
    r = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // One qualified state; model: primary on P beats the masked-Q restart
  task automatic feed(input logic [15:0] s, input int n);
    logic hit;
    hit = s == P || (orq && ((s ^ Q) & M) == 16'h0000);
    @(posedge i_mclk);
    st    <= s;
    valid <= 1'b1;
    @(posedge i_mclk);
    valid <= 1'b0;
    // Store flags stand for one cycle only, so look right after the edge
    #1 check(sto, hit);
    check(pre, !hit);
    if (!fired && armed) begin
      if (s == P) term++;
      else if (((s ^ Q) & M) == 16'h0000) term = 0;
      fired = (term == n);
    end
    repeat (2) @(posedge i_mclk);
    #1 check(trg, fired);
  endtask : feed
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    wb(0, `TSEQ_A_CTRL, 0, rd);
    check(rd, `TSEQ_CTRL_RST);
    wb(0, `TSEQ_A_ARM, 0, rd);
    check(rd, 32'h0);
    wb(0, 8'hFC, 0, rd);
    check(rd, 32'h0);
    wb(1, 8'h20, {16'hFFFF, P}, rd);
    wb(1, 8'h24, {M, Q}, rd);
    // Store on P (complex: or set B), prestore on anything not stored
    wb(1, `TSEQ_A_STO, 32'h0001_0201, rd);
    wb(1, `TSEQ_A_PRE, 32'h0010_0000, rd);
    // Primary on pattern 0 to next term, secondary on pattern 1 to term 0
    for (int i = 0; i < 8; i++) begin
      wb(1, 8'(8'h40 + 4 * i), 32'(1 | (((i + 1) % 8) << 24)), rd);
      wb(1, 8'(8'h60 + 4 * i), 32'h0000_0002, rd);
    end
    wb(1, `TSEQ_A_XTRIG, 32'h0000_0055, rd);
    // Timing mode refuses the negated arm form
    wb(1, `TSEQ_A_CTRL, 32'h0000_0130, rd);
    wb(1, `TSEQ_A_ARM, 32'h0000_0003, rd);
    wb(0, `TSEQ_A_STAT, 0, rd);
    check(rd[6], 1'b1);
    wb(1, `TSEQ_A_ARM, 32'h0, rd);
    wb(0, `TSEQ_A_STAT, 0, rd);
    check(rd[6], 1'b0);
    for (int cx = 0; cx < 2; cx++) begin
      orq = cx[0];
      for (int n = 1 + cx; n <= 5 + 2 * cx; n++) begin
        wb(1, `TSEQ_A_CTRL, 32'((n << 8) | (n << 5) | 2 | cx), rd);
        term = 0;
        fired = 1'b0;
        repeat (3) @(posedge i_mclk);
        repeat (16) begin
          rnd = xs(rnd);
          feed(rnd[2:0] == 3'h0 ? Q : (rnd[2:0] < 3'h6 ? P : rnd[31:16]), n);
        end
        wb(0, `TSEQ_A_STAT, 0, rd);
        check(rd[7], cx[0]);
        if (fired) check({xa, bnc, coordinated_measurement_bus, brk, xb}, 5'b11110);
      end
    end
    // Negated arm on line A: high at start never arms, low arms at once
    orq = 1'b0;
    wb(1, `TSEQ_A_ARM, 32'h0000_0003, rd);
    for (int k = 0; k < 2; k++) begin
      bnc_in <= ~k[0];
      wb(1, `TSEQ_A_CTRL, 32'h0000_0122, rd);
      term = 0;
      fired = 1'b0;
      armed = k[0];
      repeat (3) @(posedge i_mclk);
      bnc_in <= 1'b0;
      feed(P, 1);
      wb(0, `TSEQ_A_STAT, 0, rd);
      check(rd[3], armed);
    end
    // Initialisation restores simple mode and always armed
    wb(1, `TSEQ_A_CTRL, 32'h0000_0008, rd);
    wb(0, `TSEQ_A_CTRL, 0, rd);
    check(rd, `TSEQ_CTRL_RST);
    wb(0, `TSEQ_A_ARM, 0, rd);
    check(rd, 32'h0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
